// ---- ccu_pkg.sv ----
// Constants, register layout and state type of the capture/compare unit.
package ccu_pkg;
   localparam int NUM_CH = 7;
   localparam int CW     = 16;

   // Byte offsets on the register bus.
   localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
   localparam logic [7:0] OFS_COUNTER    = 8'h04;
   localparam logic [2:0] BLK_CHAN_CTRL  = 3'b010;
   localparam logic [2:0] BLK_CAPCOMP    = 3'b100;

   // Timer control fields.
   localparam int TC_MODE_LSB  = 0;
   localparam int TC_CLEAR_BIT = 2;
   localparam int TC_GRP_LSB   = 3;
   localparam int TC_HIZ_BIT   = 5;

   // Channel control fields.
   localparam int CC_FLAG_BIT  = 0;
   localparam int CC_COV_BIT   = 1;
   localparam int CC_OUT_BIT   = 2;
   localparam int CC_LVL_BIT   = 3;
   localparam int CC_CAP_BIT   = 4;
   localparam int CC_SYNC_BIT  = 5;
   localparam int CC_ISEL_LSB  = 6;
   localparam int CC_EDGE_LSB  = 8;
   localparam int CC_OMODE_LSB = 10;
   localparam int CC_LLD_LSB   = 13;

   // Reset values.
   localparam logic RST_HREADY = 1'b1;
   localparam logic RST_ZERO   = 1'b0;

   // Counter modes.
   localparam logic [1:0] MODE_STOP = 2'b00;
   localparam logic [1:0] MODE_UP   = 2'b01;
   localparam logic [1:0] MODE_CONT = 2'b10;
   localparam logic [1:0] MODE_UPDN = 2'b11;

   // Latch load events.
   localparam logic [1:0] LLD_IMM      = 2'b00;
   localparam logic [1:0] LLD_ZERO     = 2'b01;
   localparam logic [1:0] LLD_ZERO_PER = 2'b10;
   localparam logic [1:0] LLD_OLD      = 2'b11;

   // Latch grouping settings.
   localparam logic [1:0] GRP_NONE   = 2'b00;
   localparam logic [1:0] GRP_PAIR   = 2'b01;
   localparam logic [1:0] GRP_TRIPLE = 2'b10;
   localparam logic [1:0] GRP_ALL    = 2'b11;

   // Capture input selection.
   localparam logic [1:0] ISEL_A = 2'b00;
   localparam logic [1:0] ISEL_B = 2'b01;
   localparam logic [1:0] ISEL_G = 2'b10;
   localparam logic [1:0] ISEL_V = 2'b11;

   // Output modes.
   localparam logic [2:0] OM_OUTPUT = 3'b000;
   localparam logic [2:0] OM_SET    = 3'b001;
   localparam logic [2:0] OM_TOG_RS = 3'b010;
   localparam logic [2:0] OM_SET_RS = 3'b011;
   localparam logic [2:0] OM_TOGGLE = 3'b100;
   localparam logic [2:0] OM_RESET  = 3'b101;
   localparam logic [2:0] OM_TOG_ST = 3'b110;
   localparam logic [2:0] OM_RST_ST = 3'b111;

   localparam logic [CW-1:0] CNT_ONE = 16'h0001;
   localparam logic [CW-1:0] CNT_ZERO = 16'h0000;

   typedef struct packed {
      logic [CW-1:0]                 cnt;
      logic                          dir;
      logic [1:0]                    mode;
      logic [1:0]                    grp;
      logic                          hiz_sel;
      logic [NUM_CH-1:0][CW-1:0]     ccr;
      logic [NUM_CH-1:0][CW-1:0]     latch;
      logic [NUM_CH-1:0]             cap_sel;
      logic [NUM_CH-1:0]             sync;
      logic [NUM_CH-1:0][1:0]        isel;
      logic [NUM_CH-1:0][1:0]        edge_sel;
      logic [NUM_CH-1:0][2:0]        omode;
      logic [NUM_CH-1:0][1:0]        lld;
      logic [NUM_CH-1:0]             flag;
      logic [NUM_CH-1:0]             cov;
      logic [NUM_CH-1:0]             swout;
      logic [NUM_CH-1:0]             unread;
      logic [NUM_CH-1:0]             pend;
      logic [NUM_CH-1:0]             prev_lvl;
      logic [NUM_CH-1:0]             edge_dly;
      logic [NUM_CH-1:0]             out;
      logic [NUM_CH-1:0]             oen;
      logic [7:0]                    addr;
      logic                          wr_pend;
      logic                          rd_pend;
      logic                          hreadyout;
      logic [31:0]                   hrdata;
   } ccu_state_t;
endpackage

// ---- ccu_output_unit.sv ----
// Next-value logic of one channel output unit.
`timescale 1ns/1ps
module ccu_output_unit (
   input  wire logic [2:0] mode,
   input  wire logic       chan_equal,
   input  wire logic       period_equal,
   input  wire logic       cur,
   input  wire logic       sw_bit,
   input  wire logic       timer_clear,
   output logic            nxt
);
   always_comb begin
      nxt = cur;
      unique case (mode)
         ccu_pkg::OM_OUTPUT: nxt = sw_bit;
         ccu_pkg::OM_SET: begin
            if (chan_equal) nxt = 1'b1;
            else if (timer_clear) nxt = 1'b0;
         end
         ccu_pkg::OM_TOG_RS: begin
            if (period_equal) nxt = 1'b0;
            else if (chan_equal) nxt = ~cur;
         end
         ccu_pkg::OM_SET_RS: begin
            if (period_equal) nxt = 1'b0;
            else if (chan_equal) nxt = 1'b1;
         end
         ccu_pkg::OM_TOGGLE: begin
            if (chan_equal) nxt = ~cur;
         end
         ccu_pkg::OM_RESET: begin
            if (chan_equal) nxt = 1'b0;
         end
         ccu_pkg::OM_TOG_ST: begin
            if (period_equal) nxt = 1'b1;
            else if (chan_equal) nxt = ~cur;
         end
         ccu_pkg::OM_RST_ST: begin
            if (period_equal) nxt = 1'b1;
            else if (chan_equal) nxt = 1'b0;
         end
      endcase
   end
endmodule // ccu_output_unit

// ---- ccu_top.sv ----
// Timer counter with seven capture/compare channels behind an AHB-Lite slave.
// Operation
// - Counting down in up/down mode, a new period waits until zero is reached.
// - Counting up, a period not below the count is reached before reversing.
// - Counting up, a period below the current count starts the descent.
// - Capture-select chooses capture; input and edge fields pick source and edges.
// - A selected edge copies the counter into the register and sets the flag.
// - A status bit shows the live level of the selected capture input.
// - Synchronise bit delays each capture by one timer clock.
// - A second capture before reading sets overflow; only software clears it.
// - Both-edge capture on supply/ground: each software toggle gives one capture.
// - In compare mode counting onto the latch sets flag and equality.
// - The compare latch is hidden and loaded from the register on an event.
// - Load event 00 loads on write; 01 loads when counting to zero.
// - Event 10 adds old period in up/down; 11 loads at the old latch.
// - Latches group for joint update under the lowest channel, else channel one.
// - A controlling load event of zero disables grouping entirely.
// - Grouped latches load once all members are written and the event occurs.
// - Groupings: none, pairs from one, triples from one, all under channel one.
// - With the pin function selected and its pin high, outputs float.
// - Outputs change on the clock edge from channel and period equality.
// - Mode 0 follows the software bit, 1 sets at match, 5 resets.
// - Mode 2 toggles/resets, 3 sets/resets, 4 toggles.
// - Mode 6 toggles/sets, 7 resets/sets.
`timescale 1ns/1ps
module ccu_top (
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic                             hreadyout,
   output logic                             hresp,
   output logic [31:0]                      hrdata,
   input  wire logic [ccu_pkg::NUM_CH-1:0]  capture_input_a,
   input  wire logic [ccu_pkg::NUM_CH-1:0]  capture_input_b,
   input  wire logic                        outputs_hiz_pin,
   output logic [ccu_pkg::NUM_CH-1:0]       chan_output,
   output logic [ccu_pkg::NUM_CH-1:0]       chan_output_en
);
   ccu_pkg::ccu_state_t                     q;
   ccu_pkg::ccu_state_t                     next_q;
   logic [ccu_pkg::NUM_CH-1:0]              lvl;
   logic [ccu_pkg::NUM_CH-1:0]              sw_next;
   logic [ccu_pkg::NUM_CH-1:0]              onext;
   logic [ccu_pkg::NUM_CH-1:0]              equ;
   logic [ccu_pkg::NUM_CH-1:0]              wr_ctl;
   logic [ccu_pkg::NUM_CH-1:0]              wr_ccr;
   logic [ccu_pkg::NUM_CH-1:0][31:0]        ctl_word;
   logic [ccu_pkg::CW-1:0]                  nc;
   logic                                    nd;
   logic                                    counting;
   logic                                    at_zero;
   logic                                    at_per;
   logic                                    wr_tc;
   logic                                    wr_cnt;
   logic                                    clr;
   logic                                    is_ctl;
   logic                                    is_ccr;
   logic [2:0]                              widx;
   logic                                    edge_hit;
   logic                                    cap;
   logic                                    grouped;
   logic                                    ready;
   logic                                    ev;
   logic [2:0]                              ctl_ch;
   logic [2:0]                              ref_ch;
   logic [1:0]                              own_lld;

   // Controlling channel of a latch under a grouping setting.
   function automatic logic [2:0] ctrl_of(input logic [2:0] idx, input logic [1:0] grp);
      logic [2:0] r;
      r = idx;
      unique case (grp)
         ccu_pkg::GRP_NONE:   r = idx;
         ccu_pkg::GRP_PAIR:   r = (idx == 3'd0 || idx[0]) ? idx : 3'(idx - 3'd1);
         ccu_pkg::GRP_TRIPLE: r = (idx == 3'd0) ? 3'd0 : ((idx <= 3'd3) ? 3'd1 : 3'd4);
         ccu_pkg::GRP_ALL:    r = 3'd1;
      endcase
      return r;
   endfunction

   function automatic logic load_event(input logic [1:0] ld, input logic [1:0] mode,
                                       input logic zero, input logic per, input logic old);
      logic r;
      r = 1'b0;
      unique case (ld)
         ccu_pkg::LLD_IMM:      r = 1'b0;
         ccu_pkg::LLD_ZERO:     r = zero;
         ccu_pkg::LLD_ZERO_PER: r = zero | ((mode == ccu_pkg::MODE_UPDN) & per);
         ccu_pkg::LLD_OLD:      r = old;
      endcase
      return r;
   endfunction

   assign is_ctl = (q.addr[7:5] == ccu_pkg::BLK_CHAN_CTRL) && (q.addr[4:2] != 3'd7) && (q.addr[1:0] == 2'b00);
   assign is_ccr = (q.addr[7:5] == ccu_pkg::BLK_CAPCOMP) && (q.addr[4:2] != 3'd7) && (q.addr[1:0] == 2'b00);
   assign widx   = q.addr[4:2];
   assign wr_tc  = q.wr_pend && (q.addr == ccu_pkg::OFS_TIMER_CTRL);
   assign wr_cnt = q.wr_pend && (q.addr == ccu_pkg::OFS_COUNTER);
   assign clr    = wr_tc && hwdata[ccu_pkg::TC_CLEAR_BIT];

   genvar g;
   generate
      for (g = 0; g < ccu_pkg::NUM_CH; g++) begin : g_ch
         assign lvl[g] = (q.isel[g] == ccu_pkg::ISEL_A) ? capture_input_a[g] :
                         (q.isel[g] == ccu_pkg::ISEL_B) ? capture_input_b[g] :
                         (q.isel[g] == ccu_pkg::ISEL_V);
         assign wr_ctl[g]  = q.wr_pend && is_ctl && (widx == 3'(g));
         assign wr_ccr[g]  = q.wr_pend && is_ccr && (widx == 3'(g));
         assign sw_next[g] = wr_ctl[g] ? hwdata[ccu_pkg::CC_OUT_BIT] : q.swout[g];
         assign ctl_word[g] = {17'h0_0000, q.lld[g], q.omode[g], q.edge_sel[g], q.isel[g], q.sync[g],
                               q.cap_sel[g], lvl[g], q.swout[g], q.cov[g], q.flag[g]};
         ccu_output_unit u_out (
            .mode         (q.omode[g]),
            .chan_equal   (equ[g]),
            .period_equal (equ[0]),
            .cur          (q.out[g]),
            .sw_bit       (sw_next[g]),
            .timer_clear  (clr),
            .nxt          (onext[g])
         );
      end
   endgenerate

   always_comb begin
      next_q   = q;
      nc       = q.cnt;
      nd       = q.dir;
      equ      = '0;
      edge_hit = 1'b0;
      cap      = 1'b0;
      grouped  = 1'b0;
      ready    = 1'b0;
      ev       = 1'b0;
      ctl_ch   = 3'd0;
      ref_ch   = 3'd0;
      own_lld  = ccu_pkg::LLD_IMM;

      // Bus handshake: writes take no wait state, reads take one.
      next_q.wr_pend   = hsel && htrans[1] && hready && hwrite;
      next_q.rd_pend   = hsel && htrans[1] && hready && !hwrite;
      next_q.hreadyout = !(hsel && htrans[1] && hready && !hwrite);
      if (hsel && htrans[1] && hready) begin
         next_q.addr = haddr[7:0];
      end

      unique case (q.mode)
         ccu_pkg::MODE_STOP: nc = q.cnt;
         ccu_pkg::MODE_UP: begin
            if (q.latch[0] == ccu_pkg::CNT_ZERO || q.cnt >= q.latch[0]) nc = ccu_pkg::CNT_ZERO;
            else nc = q.cnt + ccu_pkg::CNT_ONE;
         end
         ccu_pkg::MODE_CONT: nc = q.cnt + ccu_pkg::CNT_ONE;
         ccu_pkg::MODE_UPDN: begin
            if (q.latch[0] == ccu_pkg::CNT_ZERO) begin
               nc = ccu_pkg::CNT_ZERO;
               nd = 1'b0;
            end else if (!q.dir) begin
               // Reverse only once the count meets or passes the period.
               if (q.cnt >= q.latch[0]) begin
                  nd = 1'b1;
                  nc = q.cnt - ccu_pkg::CNT_ONE;
               end else begin
                  nc = q.cnt + ccu_pkg::CNT_ONE;
               end
            end else begin
               // Descent ignores the period until zero.
               if (q.cnt == ccu_pkg::CNT_ZERO) begin
                  nc = ccu_pkg::CNT_ONE;
                  nd = 1'b0;
               end else begin
                  nc = q.cnt - ccu_pkg::CNT_ONE;
                  if (nc == ccu_pkg::CNT_ZERO) nd = 1'b0;
               end
            end
         end
      endcase
      counting = (q.mode != ccu_pkg::MODE_STOP) && (nc != q.cnt) && !clr && !wr_cnt;
      at_zero  = counting && (nc == ccu_pkg::CNT_ZERO);
      at_per   = counting && (nc == q.latch[0]);

      if (clr) begin
         next_q.cnt = ccu_pkg::CNT_ZERO;
         next_q.dir = 1'b0;
      end else if (wr_cnt) begin
         next_q.cnt = hwdata[ccu_pkg::CW-1:0];
      end else if (q.mode != ccu_pkg::MODE_STOP) begin
         next_q.cnt = nc;
         next_q.dir = nd;
      end

      if (wr_tc) begin
         next_q.mode    = hwdata[ccu_pkg::TC_MODE_LSB +: 2];
         next_q.grp     = hwdata[ccu_pkg::TC_GRP_LSB +: 2];
         next_q.hiz_sel = hwdata[ccu_pkg::TC_HIZ_BIT];
      end

      for (int i = 0; i < ccu_pkg::NUM_CH; i++) begin
         // Compare equality when counting onto the latch.
         equ[i] = !q.cap_sel[i] && counting && (nc == q.latch[i]);
         // Edge selection on the chosen input.
         edge_hit = q.cap_sel[i] &&
                    ((q.edge_sel[i][0] && lvl[i] && !q.prev_lvl[i]) ||
                     (q.edge_sel[i][1] && !lvl[i] && q.prev_lvl[i]));
         next_q.prev_lvl[i] = lvl[i];
         next_q.edge_dly[i] = edge_hit;
         cap = q.cap_sel[i] && (q.sync[i] ? q.edge_dly[i] : edge_hit);

         if (wr_ctl[i]) begin
            next_q.flag[i]     = hwdata[ccu_pkg::CC_FLAG_BIT];
            next_q.cov[i]      = hwdata[ccu_pkg::CC_COV_BIT];
            next_q.swout[i]    = hwdata[ccu_pkg::CC_OUT_BIT];
            next_q.cap_sel[i]  = hwdata[ccu_pkg::CC_CAP_BIT];
            next_q.sync[i]     = hwdata[ccu_pkg::CC_SYNC_BIT];
            next_q.isel[i]     = hwdata[ccu_pkg::CC_ISEL_LSB +: 2];
            next_q.edge_sel[i] = hwdata[ccu_pkg::CC_EDGE_LSB +: 2];
            next_q.omode[i]    = hwdata[ccu_pkg::CC_OMODE_LSB +: 3];
            next_q.lld[i]      = hwdata[ccu_pkg::CC_LLD_LSB +: 2];
         end
         if (q.rd_pend && is_ccr && widx == 3'(i)) begin
            next_q.unread[i] = 1'b0;
         end
         if (wr_ccr[i]) begin
            next_q.ccr[i] = hwdata[ccu_pkg::CW-1:0];
         end
         // Capture stores the count, sets the flag and flags overrun.
         if (cap) begin
            next_q.ccr[i]    = q.cnt;
            next_q.unread[i] = 1'b1;
            if (q.unread[i]) next_q.cov[i] = 1'b1;
         end
         if (cap || equ[i]) begin
            next_q.flag[i] = 1'b1;
         end

         // Effective load event of this latch.
         ctl_ch  = ctrl_of(3'(i), q.grp);
         grouped = (q.grp != ccu_pkg::GRP_NONE) && (q.lld[ctl_ch] != ccu_pkg::LLD_IMM);
         ref_ch  = grouped ? ctl_ch : 3'(i);
         own_lld = q.lld[ctl_ch];
         // Every member of the group must have been written.
         ready = q.pend[i];
         if (grouped) begin
            for (int j = 0; j < ccu_pkg::NUM_CH; j++) begin
               if (ctrl_of(3'(j), q.grp) == ctl_ch && !q.pend[j]) ready = 1'b0;
            end
         end
         ev = load_event(own_lld, q.mode, at_zero, at_per, counting && (nc == q.latch[ref_ch]));
         if (own_lld == ccu_pkg::LLD_IMM) begin
            next_q.pend[i] = 1'b0;
            if (wr_ccr[i]) next_q.latch[i] = hwdata[ccu_pkg::CW-1:0];
         end else if (ev && ready) begin
            next_q.latch[i] = q.ccr[i];
            next_q.pend[i]  = wr_ccr[i];
         end else begin
            next_q.pend[i]  = q.pend[i] | wr_ccr[i];
         end
      end

      // Outputs advance on the clock edge.
      next_q.out = onext;
      next_q.oen = {ccu_pkg::NUM_CH{!(q.hiz_sel && outputs_hiz_pin)}};

      if (q.rd_pend) begin
         next_q.hrdata = 32'h0000_0000;
         if (q.addr == ccu_pkg::OFS_TIMER_CTRL) begin
            next_q.hrdata = {26'h000_0000, q.hiz_sel, q.grp, 1'b0, q.mode};
         end else if (q.addr == ccu_pkg::OFS_COUNTER) begin
            next_q.hrdata = {16'h0000, q.cnt};
         end else if (is_ctl) begin
            next_q.hrdata = ctl_word[widx];
         end else if (is_ccr) begin
            next_q.hrdata = {16'h0000, q.ccr[widx]};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q           <= '0;
         q.hreadyout <= ccu_pkg::RST_HREADY;
         q.oen       <= {ccu_pkg::NUM_CH{ccu_pkg::RST_HREADY}};
      end else begin
         q <= next_q;
      end
   end

   assign hreadyout      = q.hreadyout;
   assign hresp          = ccu_pkg::RST_ZERO;
   assign hrdata         = q.hrdata;
   assign chan_output    = q.out;
   assign chan_output_en = q.oen;
endmodule // ccu_top

// ---- ccu_sva.sv ----
// Checker of bus timing, reset values and output enables of the capture/compare unit.
`timescale 1ns/1ps
module ccu_sva (
   input wire logic                       hclk,
   input wire logic                       hresetn,
   input wire logic                       hsel,
   input wire logic [1:0]                 htrans,
   input wire logic                       hwrite,
   input wire logic                       hready,
   input wire logic                       hreadyout,
   input wire logic [31:0]                hrdata,
   input wire logic                       outputs_hiz_pin,
   input wire logic [ccu_pkg::NUM_CH-1:0] chan_output,
   input wire logic [ccu_pkg::NUM_CH-1:0] chan_output_en
);
   wire logic rd_take;
   wire logic wr_take;
   assign rd_take = hsel && htrans[1] && hready && !hwrite;
   assign wr_take = hsel && htrans[1] && hready && hwrite;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   property p_read_wait;
      rd_take |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
   property p_write_nowait;
      wr_take |=> hreadyout;
   endproperty
   a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
   property p_wait_cause;
      $fell(hreadyout) |-> $past(rd_take);
   endproperty
   a_wait_cause: assert property (p_wait_cause) else $error("wait state without read");
   property p_rdata_hold;
      $past(hreadyout) |-> $stable(hrdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed outside read");
   property p_hiz_cause;
      !chan_output_en[0] |-> $past(outputs_hiz_pin);
   endproperty
   a_hiz_cause: assert property (p_hiz_cause) else $error("outputs floated without pin");
   property p_hiz_all;
      (chan_output_en == '0) || (&chan_output_en);
   endproperty
   a_hiz_all: assert property (p_hiz_all) else $error("outputs enabled unevenly");
   property p_hiz_release;
      !outputs_hiz_pin |=> &chan_output_en;
   endproperty
   a_hiz_release: assert property (p_hiz_release) else $error("outputs float with pin low");
   property p_reset_clear;
      $rose(hresetn) |-> (chan_output == '0) && (&chan_output_en) && (hrdata == 32'h0000_0000);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");
endmodule // ccu_sva

bind ccu_top ccu_sva ccu_sva_i (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .outputs_hiz_pin(outputs_hiz_pin),
   .chan_output(chan_output), .chan_output_en(chan_output_en)
);

// ---- ccu_pins.sv ----
// Far-side model: capture sources, the output-disable pin and the channel pin wires.
`timescale 1ns/1ps
module ccu_pins (
   input  wire logic [ccu_pkg::NUM_CH-1:0] a_req,
   input  wire logic                       hclk,
   input  wire logic                       hiz_req,
   input  wire logic [ccu_pkg::NUM_CH-1:0] chan_output,
   input  wire logic [ccu_pkg::NUM_CH-1:0] chan_output_en,
   output logic [ccu_pkg::NUM_CH-1:0]      capture_input_a,
   output logic [ccu_pkg::NUM_CH-1:0]      capture_input_b,
   output logic                            outputs_hiz_pin,
   output logic [ccu_pkg::NUM_CH-1:0]      pin_level
);
   logic [ccu_pkg::NUM_CH-1:0] last_drv = '0;
   always @(posedge hclk) begin
      capture_input_a <= a_req;
      capture_input_b <= {a_req[0], a_req[ccu_pkg::NUM_CH-1:1]};
      outputs_hiz_pin <= hiz_req;
      last_drv <= (chan_output_en & chan_output) | (~chan_output_en & last_drv);
   end
   assign pin_level = (chan_output_en & chan_output) | (~chan_output_en & ~last_drv);
endmodule // ccu_pins

// ---- tb_top.sv ----
// Self-checking bench for the capture/compare unit.
`timescale 1ns/1ps
module tb_top;
   logic                       hclk = 1'b0;
   logic                       hresetn = 1'b0;
   logic                       hsel = 1'b0;
   logic [31:0]                haddr = 32'h0000_0000;
   logic [1:0]                 htrans = 2'b00;
   logic                       hwrite = 1'b0;
   logic [31:0]                hwdata = 32'h0000_0000;
   logic                       hiz_req = 1'b0;
   logic [ccu_pkg::NUM_CH-1:0] a_req = '0;
   logic                       hreadyout;
   logic                       hresp;
   logic [31:0]                hrdata;
   logic [ccu_pkg::NUM_CH-1:0] cap_a, cap_b, chan_out, chan_en, pin_level;
   logic                       hiz_pin;
   logic [31:0]                rdv;
   logic                       e, ex;
   int                         bad_count = 0;
   int                         check_count = 0;
   logic [31:0] caps [3] = '{32'h0000_1234, 32'h0000_0055, 32'h0000_0066};
   logic [2:0]  modes [7] = '{3'h1, 3'h5, 3'h3, 3'h2, 3'h7, 3'h6, 3'h4};
   wire logic [31:0] all_en = 32'((1 << ccu_pkg::NUM_CH) - 1);

   always #25 hclk = ~hclk;

   ccu_top ccu_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .capture_input_a(cap_a), .capture_input_b(cap_b),
      .outputs_hiz_pin(hiz_pin), .chan_output(chan_out), .chan_output_en(chan_en));
   ccu_pins ccu_pins_i (.hclk(hclk), .a_req(a_req), .hiz_req(hiz_req), .chan_output(chan_out),
      .chan_output_en(chan_en), .capture_input_a(cap_a), .capture_input_b(cap_b),
      .outputs_hiz_pin(hiz_pin), .pin_level(pin_level));

   task automatic close_out();
      if (bad_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wait_rdy();
      int n;
      n = 0;
      @(negedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            bad_count++;
            close_out();
         end
         @(negedge hclk);
      end
      rdv = hrdata;
      @(posedge hclk);
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h00_0000, a};
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(nm, rdv, exp);
   endtask

   task automatic run_cnt(input logic [31:0] start, input int n);
      bus(1'b1, 8'h04, 32'h0000_0005);
      bus(1'b1, 8'h00, start);
      repeat (n) @(posedge hclk);
      bus(1'b1, 8'h00, {start[31:2], 2'b00});
   endtask

   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      chk("out_rst", 32'(chan_out), 32'h0000_0000);
      chk("en_rst", 32'(chan_en), all_en);
      rchk("ctl1_rst", 8'h44, 32'h0000_0000);
      rchk("ccr3_rst", 8'h8C, 32'h0000_0000);
      rchk("unmapped", 8'hFC, 32'h0000_0000);
      bus(1'b1, 8'h44, 32'h0000_0130);
      bus(1'b1, 8'h40, 32'h0000_0170);
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, 8'h04, caps[k]);
         a_req[1] <= 1'b1;
         repeat (4) @(posedge hclk);
         if (k == 0) begin
            rchk("cap_first", 8'h84, caps[0]);
            rchk("ctl_level", 8'h44, 32'h0000_0139);
         end
         a_req[1] <= 1'b0;
         repeat (4) @(posedge hclk);
      end
      rchk("cap_last", 8'h84, caps[2]);
      rchk("cap_b", 8'h80, caps[2]);
      rchk("ctl_ovf", 8'h44, 32'h0000_0133);
      bus(1'b1, 8'h44, 32'h0000_0130);
      rchk("ctl_clr", 8'h44, 32'h0000_0130);
      bus(1'b1, 8'h48, 32'h0000_03B0);
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, 8'h04, caps[k]);
         bus(1'b1, 8'h48, k[0] ? 32'h0000_03B0 : 32'h0000_03F0);
         repeat (4) @(posedge hclk);
         rchk("sw_cap", 8'h88, caps[k]);
      end
      bus(1'b1, 8'h40, 32'h0000_0000);
      bus(1'b1, 8'h44, 32'h0000_0000);
      bus(1'b1, 8'h80, 32'h0000_0009);
      bus(1'b1, 8'h84, 32'h0000_0004);
      for (int k = 0; k < 7; k++) begin
         bus(1'b1, 8'h44, 32'(modes[k]) << 10);
         bus(1'b1, 8'h00, 32'h0000_0005);
         repeat (25) @(posedge hclk);
         bus(1'b1, 8'h00, 32'h0000_0000);
         bus(1'b0, 8'h04, 32'h0000_0000);
         e = (rdv >= 32'h0000_0004) && (rdv <= 32'h0000_0008);
         ex = (modes[k] == 3'h1 || modes[k] == 3'h4) ? 1'b1 : (modes[k] == 3'h5) ? 1'b0 : (modes[k][2] ? ~e : e);
         chk("out_mode", 32'(chan_out[1]), 32'(ex));
         if (k == 0) begin
            rchk("ctl_match", 8'h44, 32'h0000_0401);
         end
      end
      bus(1'b1, 8'h00, 32'h0000_0008);
      bus(1'b1, 8'h44, 32'h0000_2000);
      bus(1'b1, 8'h48, 32'h0000_0000);
      bus(1'b1, 8'h84, 32'h0000_0002);
      run_cnt(32'h0000_0009, 6);
      rchk("grp_wait", 8'h44, 32'h0000_2000);
      bus(1'b1, 8'h88, 32'h0000_0002);
      run_cnt(32'h0000_0009, 6);
      rchk("grp_load", 8'h44, 32'h0000_2001);
      bus(1'b1, 8'h44, 32'h0000_0000);
      bus(1'b1, 8'h48, 32'h0000_2000);
      bus(1'b1, 8'h88, 32'h0000_0006);
      run_cnt(32'h0000_0009, 1);
      rchk("grp_off", 8'h48, 32'h0000_2001);
      bus(1'b1, 8'h80, 32'h0000_0003);
      run_cnt(32'h0000_000B, 1);
      bus(1'b0, 8'h04, 32'h0000_0000);
      chk("updn_down", 32'(rdv < 32'h0000_0005), 32'h0000_0001);
      bus(1'b1, 8'h44, 32'h0000_0004);
      @(posedge hclk);
      chk("out_sw", 32'(chan_out[1]), 32'h0000_0001);
      bus(1'b1, 8'h00, 32'h0000_0020);
      hiz_req <= 1'b1;
      repeat (4) @(posedge hclk);
      chk("en_hiz", 32'(chan_en), 32'h0000_0000);
      hiz_req <= 1'b0;
      repeat (4) @(posedge hclk);
      chk("en_drv", 32'(chan_en), all_en);
      chk("pin", 32'(pin_level), 32'(chan_out));
      close_out();
   end
endmodule // tb_top
